// [rtl/adcr_pkg.sv]
`default_nettype none
package adcr_pkg;
    // ==========================================
    // register word addresses
    localparam logic [7:0] ADDR_CTRL_0 = 8'h00;
    localparam logic [7:0] ADDR_CTRL_1 = 8'h04;
    localparam logic [7:0] ADDR_RES_HIGH = 8'h08;
    localparam logic [7:0] ADDR_RES_LOW = 8'h0c;
    localparam logic [7:0] ADDR_IRQ_FLAG = 8'h10;
    localparam logic [7:0] ADDR_IRQ_ENABLE = 8'h14;
    localparam logic [7:0] ADDR_IRQ_CLEAR = 8'h18;
    // ==========================================
    // field positions
    localparam int CTRL0_GO_BIT = 1;
    localparam int CTRL0_ON_BIT = 0;
    localparam int CTRL1_FMT_BIT = 7;
    localparam int IRQ_DONE_BIT = 6;
    localparam logic [7:0] CTRL0_MASK = 8'h7f;
    localparam logic [7:0] CTRL1_MASK = 8'hf7;
    localparam logic [7:0] IRQ_MASK = 8'h40;
    // ==========================================
    // reset values
    localparam logic [7:0] CTRL0_RST = 8'h00;
    localparam logic [7:0] CTRL1_RST = 8'h00;
    localparam logic [7:0] RES_RST = 8'h00;
    // ==========================================
    // conversion timing: eleven bit periods per conversion
    localparam int CONV_TICKS = 11;
    localparam logic [4:0] CONV_TICKS_M1 = 5'h0a;

    typedef enum logic [0:0] {
        ST_IDLE = 1'b0,
        ST_CONV = 1'b1
    } adcr_state_t;

    typedef struct packed {
        logic [31:0] haddr;
        logic [1:0] htrans;
        logic hwrite;
        logic [2:0] hsize;
        logic hsel;
        logic hready;
    } adcr_ahb_req_t;

    typedef struct packed {
        adcr_state_t st;
        logic [4:0] cnt;
        logic [7:0] ctrl0;
        logic [7:0] ctrl1;
        logic [7:0] res_high;
        logic [7:0] res_low;
        logic [7:0] irq_flag;
        logic [7:0] irq_en;
        logic dp_wr;
        logic [7:0] dp_addr;
        logic [31:0] rdata;
        logic sample_req;
    } adcr_state_s_t;

    // justify a 10-bit result into {high, low}
    function automatic logic [15:0] adcr_justify(input logic [9:0] res, input logic right);
        if (right)
            adcr_justify = {6'h00, res};
        else
            adcr_justify = {res, 6'h00};
    endfunction
endpackage
`default_nettype wire

// [rtl/adcr_regs.sv]
// Functional notes
// - format 0 puts result bits 9..2 in high byte bits 7..0.
// - format 0 puts result bits 1..0 in low byte bits 7..6, rest zero.
// - format 1 puts result bits 9..8 in high byte bits 1..0, rest zero.
// - format 1 puts result bits 7..0 in low byte.
// - result bytes read/write; hold value, loaded only by writes or completion.
// - control 0: channel bits 6..2, start/done bit 1, enable bit 0, bit 7 zero.
// - control 1: format 7, clock 6..4, nref 2, pref 1..0, bit 3 zero.
// - completion flag and its enable sit at bit 6 of flag/enable registers.
// - setting start/done begins conversion; hardware clears it at completion.
// - enable low disables converter and aborts conversions.
`default_nettype none
module adcr_regs
    import adcr_pkg::*;
(
    // clock and reset
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic ce_i,
    // ahb-lite slave
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic [31:0] hwdata_i,
    input wire logic hready_i,
    output logic [31:0] hrdata_o,
    output logic hreadyout_o,
    output logic hresp_o,
    // converter core
    input wire logic [9:0] conv_result_i,
    output logic [4:0] channel_sel_o,
    output logic converter_enable_o,
    output logic [2:0] conv_clock_sel_o,
    output logic neg_ref_sel_o,
    output logic [1:0] pos_ref_sel_o,
    output logic sample_o,
    // interrupt
    output logic irq_o
);
    // ==========================================
    // state
    adcr_state_s_t s, next_s;
    adcr_ahb_req_t req;
    logic [7:0] wbyte;
    logic [15:0] just;

    assign req = '{haddr: haddr_i, htrans: htrans_i, hwrite: hwrite_i, hsize: hsize_i, hsel: hsel_i,
                   hready: hready_i};
    assign wbyte = hwdata_i[7:0];
    assign just = adcr_justify(conv_result_i, s.ctrl1[CTRL1_FMT_BIT]);

    // ==========================================
    // next state
    always_comb
    begin
        next_s = s;
        next_s.sample_req = 1'b0;
        // address phase capture
        next_s.dp_wr = 1'b0;
        if (req.hsel && req.hready && req.htrans[1])
        begin
            next_s.dp_wr = req.hwrite;
            next_s.dp_addr = req.haddr[7:0];
            next_s.rdata = 32'h0000_0000;
            if (!req.hwrite)
            begin
                unique case (req.haddr[7:0])
                    ADDR_CTRL_0: next_s.rdata = {24'h000000, s.ctrl0 & CTRL0_MASK};
                    ADDR_CTRL_1: next_s.rdata = {24'h000000, s.ctrl1 & CTRL1_MASK};
                    ADDR_RES_HIGH: next_s.rdata = {24'h000000, s.res_high};
                    ADDR_RES_LOW: next_s.rdata = {24'h000000, s.res_low};
                    ADDR_IRQ_FLAG: next_s.rdata = {24'h000000, s.irq_flag};
                    ADDR_IRQ_ENABLE: next_s.rdata = {24'h000000, s.irq_en};
                    default: next_s.rdata = 32'h0000_0000;
                endcase
            end
        end
        // data phase writes
        if (s.dp_wr)
        begin
            unique case (s.dp_addr)
                ADDR_CTRL_0: next_s.ctrl0 = wbyte & CTRL0_MASK;
                ADDR_CTRL_1: next_s.ctrl1 = wbyte & CTRL1_MASK;
                ADDR_RES_HIGH: next_s.res_high = wbyte;
                ADDR_RES_LOW: next_s.res_low = wbyte;
                ADDR_IRQ_ENABLE: next_s.irq_en = wbyte & IRQ_MASK;
                ADDR_IRQ_CLEAR: next_s.irq_flag = s.irq_flag & ~(wbyte & IRQ_MASK);
                default: ;
            endcase
        end
        // conversion sequencer
        unique case (s.st)
            ST_IDLE:
            begin
                if (next_s.ctrl0[CTRL0_GO_BIT] && next_s.ctrl0[CTRL0_ON_BIT])
                begin
                    next_s.st = ST_CONV;
                    next_s.cnt = CONV_TICKS_M1;
                    next_s.sample_req = 1'b1;
                end
                else
                    next_s.ctrl0[CTRL0_GO_BIT] = 1'b0;
            end
            ST_CONV:
            begin
                if (!next_s.ctrl0[CTRL0_ON_BIT] || !next_s.ctrl0[CTRL0_GO_BIT])
                begin
                    next_s.st = ST_IDLE;
                    next_s.ctrl0[CTRL0_GO_BIT] = 1'b0;
                end
                else if (s.cnt == 5'h00)
                begin
                    next_s.st = ST_IDLE;
                    next_s.res_high = just[15:8];
                    next_s.res_low = just[7:0];
                    next_s.ctrl0[CTRL0_GO_BIT] = 1'b0;
                    next_s.irq_flag[IRQ_DONE_BIT] = 1'b1;
                end
                else
                    next_s.cnt = s.cnt - 5'h01;
            end
        endcase
    end

    // ==========================================
    // registers
    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            s <= '{st: ST_IDLE, cnt: 5'h00, ctrl0: CTRL0_RST, ctrl1: CTRL1_RST, res_high: RES_RST,
                   res_low: RES_RST, irq_flag: 8'h00, irq_en: 8'h00, dp_wr: 1'b0, dp_addr: 8'h00,
                   rdata: 32'h0000_0000, sample_req: 1'b0};
        end
        else if (ce_i)
        begin
            s <= next_s;
        end
    end

    // ==========================================
    // outputs
    assign hrdata_o = s.rdata;
    assign hreadyout_o = 1'b1;
    assign hresp_o = 1'b0;
    assign channel_sel_o = s.ctrl0[6:2];
    assign converter_enable_o = s.ctrl0[CTRL0_ON_BIT];
    assign conv_clock_sel_o = s.ctrl1[6:4];
    assign neg_ref_sel_o = s.ctrl1[2];
    assign pos_ref_sel_o = s.ctrl1[1:0];
    assign sample_o = s.sample_req;
    assign irq_o = |(s.irq_flag & s.irq_en);

    // ==========================================
    // checks
    done_loads_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
        (ce_i && s.st == ST_CONV && s.cnt == 5'h00 && s.ctrl0[0] && s.ctrl0[1] && !s.dp_wr)
        |=> (s.res_high == $past(just[15:8]) && s.res_low == $past(just[7:0]) && !s.ctrl0[1] && s.irq_flag[6]))
        else $error("completion did not load result");

    left_high_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
        !s.ctrl1[7]
        |-> just[15:8] == conv_result_i[9:2])
        else $error("left high byte wrong");

    left_low_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
        !s.ctrl1[7]
        |-> just[7:0] == {conv_result_i[1:0], 6'h00})
        else $error("left low byte wrong");

    right_high_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
        s.ctrl1[7]
        |-> just[15:8] == {6'h00, conv_result_i[9:8]})
        else $error("right high byte wrong");

    right_low_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
        s.ctrl1[7]
        |-> just[7:0] == conv_result_i[7:0])
        else $error("right low byte wrong");

    result_hold_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
        (s.st == ST_IDLE && !s.dp_wr)
        |=> $stable(s.res_high) && $stable(s.res_low))
        else $error("result changed without cause");

    ctrl_unimpl_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
        !s.ctrl0[7]
        && !s.ctrl1[3])
        else $error("unimplemented bit set");

    conv_length_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
        ($rose(s.st == ST_CONV) && ce_i)
        |-> ##[1:20] (s.st == ST_IDLE || !ce_i))
        else $error("conversion too long");

    off_idle_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
        (ce_i && !s.dp_wr && !s.ctrl0[0])
        |=> s.st == ST_IDLE && !s.ctrl0[1])
        else $error("converter ran while disabled");

    irq_level_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
        irq_o
        == (s.irq_flag[6] && s.irq_en[6]))
        else $error("interrupt level wrong");

    bus_okay_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
        hreadyout_o
        && !hresp_o)
        else $error("bus not ready or not okay");

    rd_upper_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
        1'b1
        |-> hrdata_o[31:8] == 24'h000000)
        else $error("upper read data not zero");

    rd_ctrl0_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
        (ce_i && hsel_i && hready_i && htrans_i[1] && !hwrite_i && haddr_i[7:0] == ADDR_CTRL_0)
        |=> hrdata_o[7:0] == {1'b0, $past(s.ctrl0[6:0])})
        else $error("control 0 read wrong");

    rd_ctrl1_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
        (ce_i && hsel_i && hready_i && htrans_i[1] && !hwrite_i && haddr_i[7:0] == ADDR_CTRL_1)
        |=> !hrdata_o[3] && hrdata_o[7:4] == $past(s.ctrl1[7:4]) && hrdata_o[2:0] == $past(s.ctrl1[2:0]))
        else $error("control 1 read wrong");

    rd_high_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
        (ce_i && hsel_i && hready_i && htrans_i[1] && !hwrite_i && haddr_i[7:0] == ADDR_RES_HIGH)
        |=> hrdata_o[7:0] == $past(s.res_high))
        else $error("high result read wrong");

    rd_low_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
        (ce_i && hsel_i && hready_i && htrans_i[1] && !hwrite_i && haddr_i[7:0] == ADDR_RES_LOW)
        |=> hrdata_o[7:0] == $past(s.res_low))
        else $error("low result read wrong");

    rd_flag_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
        (ce_i && hsel_i && hready_i && htrans_i[1] && !hwrite_i && haddr_i[7:0] == ADDR_IRQ_FLAG)
        |=> hrdata_o[7:0] == $past(s.irq_flag))
        else $error("flag read wrong");

    clear_reads_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
        (ce_i && hsel_i && hready_i && htrans_i[1] && !hwrite_i && haddr_i[7:0] == ADDR_IRQ_CLEAR)
        |=> hrdata_o == 32'h0000_0000)
        else $error("clear register read not zero");

    ctrl0_write_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
        (ce_i && s.dp_wr && s.dp_addr == ADDR_CTRL_0)
        |=> channel_sel_o == $past(hwdata_i[6:2]) && converter_enable_o == $past(hwdata_i[0]))
        else $error("control 0 write lost");

    ctrl1_write_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
        (ce_i && s.dp_wr && s.dp_addr == ADDR_CTRL_1)
        |=> conv_clock_sel_o == $past(hwdata_i[6:4]) && neg_ref_sel_o == $past(hwdata_i[2])
            && pos_ref_sel_o == $past(hwdata_i[1:0]) && s.ctrl1[7] == $past(hwdata_i[7]) && !s.ctrl1[3])
        else $error("control 1 write lost");

    high_write_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
        (ce_i && s.dp_wr && s.dp_addr == ADDR_RES_HIGH && s.st == ST_IDLE)
        |=> s.res_high == $past(hwdata_i[7:0]))
        else $error("high result write lost");

    low_write_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
        (ce_i && s.dp_wr && s.dp_addr == ADDR_RES_LOW && s.st == ST_IDLE)
        |=> s.res_low == $past(hwdata_i[7:0]))
        else $error("low result write lost");

    sample_pulse_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
        (ce_i && sample_o)
        |=> !sample_o)
        else $error("sample longer than one cycle");

    sample_start_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
        $rose(s.st == ST_CONV)
        |-> sample_o)
        else $error("conversion began without sample");

    start_enable_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
        (ce_i && s.st == ST_IDLE && !s.dp_wr && !(s.ctrl0[1] && s.ctrl0[0]))
        |=> s.st == ST_IDLE)
        else $error("conversion began unarmed");

    conv_armed_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
        s.st == ST_CONV
        |-> s.ctrl0[1] && s.ctrl0[0])
        else $error("converting with start or enable low");

    idle_go_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
        s.st == ST_IDLE
        |-> !s.ctrl0[1])
        else $error("start bit set while idle");

    cnt_range_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
        s.st == ST_CONV
        |-> s.cnt <= CONV_TICKS_M1)
        else $error("countdown out of range");

    abort_keeps_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
        (ce_i && s.st == ST_CONV && s.dp_wr && s.dp_addr == ADDR_CTRL_0 && !(hwdata_i[1] && hwdata_i[0]))
        |=> s.st == ST_IDLE && $stable(s.res_high) && $stable(s.res_low))
        else $error("abort loaded a result");

    set_wins_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
        (ce_i && s.st == ST_CONV && s.cnt == 5'h00 && s.dp_wr && s.dp_addr == ADDR_IRQ_CLEAR)
        |=> s.irq_flag[6])
        else $error("clear beat completion flag");

    flag_clear_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
        (ce_i && s.dp_wr && s.dp_addr == ADDR_IRQ_CLEAR && hwdata_i[6] && !(s.st == ST_CONV && s.cnt == 5'h00))
        |=> !s.irq_flag[6])
        else $error("flag not cleared");

    flag_bits_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
        (s.irq_flag & ~IRQ_MASK) == 8'h00
        && (s.irq_en & ~IRQ_MASK) == 8'h00)
        else $error("flag or enable outside bit 6");

    enable_write_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
        (ce_i && s.dp_wr && s.dp_addr == ADDR_IRQ_ENABLE)
        |=> s.irq_en[6] == $past(hwdata_i[6]))
        else $error("enable write lost");

    ce_freeze_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
        !ce_i
        |=> $stable(s))
        else $error("state moved while clock enable low");
endmodule // adcr_regs
`default_nettype wire

// [verification/adcr_analog_model.sv]
`default_nettype none
module adcr_analog_model
(
    // converter handshake
    input wire logic clk_i,
    input wire logic sample_i,
    input wire logic [4:0] channel_sel_i,
    input wire logic [9:0] level_i,
    // digitised value
    output logic [9:0] conv_result_o
);
    timeunit 1ns;
    timeprecision 1ns;
    // ==========================================
    // hold capacitor: level captured at sample, tagged by channel
    logic [9:0] held = 10'h000;
    always @(posedge clk_i)
    begin
        if (sample_i)
            held <= level_i ^ {5'h00, channel_sel_i};
    end
    assign conv_result_o = held;
endmodule // adcr_analog_model
`default_nettype wire

// [verification/adc_result_and_control_regs_bench.sv]
`default_nettype none
module adc_result_and_control_regs_bench;
    import adcr_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    // ==========================================
    // stimulus and observation
    logic clk = 1'b0, nrst = 1'b0, ce = 1'b1, hsel = 1'b0, hwrite = 1'b0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2;
    logic hready, sample, irq;
    logic [4:0] chan;
    logic [9:0] res, level = 10'h2b5;
    int err_total = 0, samples_checked = 0;
    always #50 clk = ~clk;
    adcr_regs u_dut (.clk_i(clk), .nrst_i(nrst), .ce_i(ce), .hsel_i(hsel), .haddr_i(haddr),
        .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(hsize), .hwdata_i(hwdata), .hready_i(hready),
        .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(), .conv_result_i(res), .channel_sel_o(chan),
        .converter_enable_o(), .conv_clock_sel_o(), .neg_ref_sel_o(), .pos_ref_sel_o(),
        .sample_o(sample), .irq_o(irq));
    adcr_analog_model u_core (.clk_i(clk), .sample_i(sample), .channel_sel_i(chan), .level_i(level),
        .conv_result_o(res));
    // ==========================================
    // bus, check and conversion tasks
    task automatic tally_and_finish();
        if (err_total == 0 && samples_checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic wait_ready();
        int n;
        n = 0;
        @(posedge clk);
        while (hready !== 1'b1)
        begin
            n++;
            if (n > 20)
            begin
                err_total++;
                tally_and_finish();
            end
            @(posedge clk);
        end
    endtask
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= wr;
        wait_ready();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        wait_ready();
        rd = hrdata;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            err_total++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic convert(input logic fmt, input logic [4:0] ch);
        logic [9:0] r;
        int n;
        r = level ^ {5'h00, ch};
        xfer(1'b1, ADDR_CTRL_1, {24'h0, fmt, 7'h00});
        xfer(1'b1, ADDR_CTRL_0, {25'h0, ch, 2'b01});
        repeat (45) @(posedge clk);
        xfer(1'b1, ADDR_CTRL_0, {25'h0, ch, 2'b11});
        xfer(1'b0, ADDR_CTRL_0, 32'h0);
        chk({31'h0, rd[1]}, 32'h1);
        n = 0;
        while (rd[1] === 1'b1 && n < 40)
        begin
            xfer(1'b0, ADDR_CTRL_0, 32'h0);
            n++;
        end
        chk(rd, {25'h0, ch, 2'b01});
        xfer(1'b0, ADDR_RES_HIGH, 32'h0);
        chk(rd, fmt ? {30'h0, r[9:8]} : {24'h0, r[9:2]});
        xfer(1'b0, ADDR_RES_LOW, 32'h0);
        chk(rd, fmt ? {24'h0, r[7:0]} : {24'h0, r[1:0], 6'h00});
        xfer(1'b0, ADDR_IRQ_FLAG, 32'h0);
        chk(rd, 32'h40);
        chk({31'h0, irq}, 32'h0);
        xfer(1'b1, ADDR_IRQ_ENABLE, 32'h40);
        xfer(1'b0, ADDR_IRQ_ENABLE, 32'h0);
        chk(rd, 32'h40);
        chk({31'h0, irq}, 32'h1);
        xfer(1'b1, ADDR_IRQ_CLEAR, 32'h40);
        xfer(1'b0, ADDR_IRQ_FLAG, 32'h0);
        chk(rd, 32'h0);
        chk({31'h0, irq}, 32'h0);
        xfer(1'b1, ADDR_IRQ_ENABLE, 32'h0);
    endtask
    // ==========================================
    // main sequence
    initial
    begin
        repeat (5) @(posedge clk);
        nrst <= 1'b1;
        xfer(1'b0, ADDR_CTRL_0, 32'h0);
        chk(rd, 32'h0);
        xfer(1'b1, ADDR_CTRL_1, 32'hff);
        xfer(1'b0, ADDR_CTRL_1, 32'h0);
        chk(rd, 32'hf7);
        xfer(1'b1, ADDR_CTRL_0, 32'hfd);
        xfer(1'b0, ADDR_CTRL_0, 32'h0);
        chk(rd, 32'h7d);
        chk({27'h0, chan}, 32'h1f);
        xfer(1'b1, ADDR_RES_HIGH, 32'ha5);
        xfer(1'b0, ADDR_RES_HIGH, 32'h0);
        chk(rd, 32'ha5);
        ce <= 1'b0;
        xfer(1'b1, ADDR_RES_HIGH, 32'h5a);
        ce <= 1'b1;
        xfer(1'b0, ADDR_RES_HIGH, 32'h0);
        chk(rd, 32'ha5);
        convert(1'b0, 5'h13);
        convert(1'b1, 5'h0c);
        xfer(1'b1, ADDR_CTRL_0, 32'h02);
        repeat (3) @(posedge clk);
        xfer(1'b0, ADDR_CTRL_0, 32'h0);
        chk(rd, 32'h0);
        xfer(1'b0, ADDR_IRQ_FLAG, 32'h0);
        chk(rd, 32'h0);
        xfer(1'b0, 8'h1c, 32'h0);
        chk(rd, 32'h0);
        tally_and_finish();
    end
endmodule // adc_result_and_control_regs_bench
`default_nettype wire
